// File: sdram_area_port.sv
// SDRAM area port: decode, command sequencing, lanes and pins
// Notes on behaviour
// - Area-two select goes low for addresses 0800_0000 to 0BFF_FFFF.
// - Area-three select goes low for addresses 0C00_0000 to 0FFF_FFFF.
// - Areas 0, 1, 4, 5, 6 are ignored and cause no SDRAM pin activity.
// - Bus width 16, 32 or 64 per control field; only those lanes used.
// - For 64-bit width the lane pin is low at reset, routing upper lanes.
// - Endian pin sampled at reset: 0 big endian, 1 little endian.
// - Eight byte masks, mask 7 for bits 63..56 down to mask 0.
// - Write-enable line low for write commands, high for reads.
// - Row and column strobes qualify multiplexed row and column address.
// - Clock enable high in normal use, low for power-down.
// - Free-running SDRAM clock; all pins timed against it.
// - Data bus driven only in write data phase, released otherwise.
`timescale 1ns/1ps
`include "sdram_defines.svh"
module sdram_area_port
  import sdram_pkg::*;
#(
  parameter int DIV      = `CLK_DIV,
  parameter int TRCD     = `TRCD_CK,
  parameter int CAS_LAT  = `CAS_LAT,
  parameter int COL_BITS = `COL_BITS,
  parameter int ROW_BITS = `ROW_BITS
) (
  input  wire logic                     SYS_CLK,
  input  wire logic                     RESET,
  input  wire logic                     REQ_VALID,
  input  wire req_s                     REQ,
  output logic                          REQ_READY,
  output logic                          REQ_IGNORED,
  output logic                          RD_VALID,
  output logic [63:0]                   RD_DATA,
  output logic                          WR_DONE,
  input  wire width_e                   BUS_WIDTH_FIELD_A,
  input  wire width_e                   BUS_WIDTH_FIELD_B,
  input  wire logic                     LOW_POWER,
  input  wire logic                     ENDIAN_MODE_PIN,
  input  wire logic                     LANE_SELECT_PIN,
  output logic                          LITTLE_ENDIAN,
  output logic                          UPPER_LANES_SDRAM,
  output logic                          WIDTH_CONFLICT,
  output logic [`SDRAM_ADDR_W-1:0]      SDRAM_ADDR_OUT,
  output logic [63:0]                   SDRAM_DATA_IO_OUT,
  output logic                          SDRAM_DATA_IO_OE,
  input  wire logic [63:0]              SDRAM_DATA_IO_IN,
  output logic                          AREA2_SELECT_N,
  output logic                          AREA3_SELECT_N,
  output logic                          ROW_STROBE_N,
  output logic                          COL_STROBE_N,
  output logic                          SDRAM_WRITE_EN_N,
  output logic [7:0]                    BYTE_MASK,
  output logic                          SDRAM_CLK_EN,
  output logic                          SDRAM_CLK_OUT
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RCD  = 3'b001,
    ST_CAS  = 3'b010,
    ST_WREL = 3'b011,
    ST_DONE = 3'b100
  } state_e;

  state_e       state_reg;
  req_s         cur_reg;
  width_e       width_reg;
  cmd_s         cmd_reg;
  logic [3:0]   cnt_reg;
  logic         busy_reg;
  logic         area3_reg;
  logic         little_reg;
  logic         lane_reg;
  logic         cke_reg;
  logic         rise_en;
  logic         fall_en;
  logic [1:0]   mode_sync;
  logic [63:0]  dq_sync;
  logic         in_a2;
  logic         in_a3;
  logic         take;
  logic         issue_act;
  logic         issue_col;
  logic         capture;
  logic [7:0]   lanes;
  logic [`ADDR_W-1:0] word;

  function automatic logic [7:0] lanes_of(input width_e w);
    unique case (w)
      W32:     lanes_of = `LANES_32;
      W64:     lanes_of = `LANES_64;
      default: lanes_of = `LANES_16;
    endcase
  endfunction : lanes_of

  // Big endian mirrors the bytes inside the active width only
  function automatic logic [63:0] order_bytes(input logic [63:0] d, input width_e w,
                                              input logic big);
    int n;
    n = (w == W64) ? 8 : (w == W32) ? 4 : 2;
    order_bytes = d;
    for (int k = 0; k < 8; k++) begin
      if (big && k < n) begin
        order_bytes[8*k +: 8] = d[8*(n-1-k) +: 8];
      end
    end
  endfunction : order_bytes

  function automatic logic [7:0] order_bits(input logic [7:0] b, input width_e w,
                                            input logic big);
    logic [63:0] wide;
    logic [63:0] sorted;
    wide = '0;
    for (int k = 0; k < 8; k++) begin
      wide[8*k] = b[k];
    end
    sorted = order_bytes(wide, w, big);
    for (int k = 0; k < 8; k++) begin
      order_bits[k] = sorted[8*k];
    end
  endfunction : order_bits

  sdram_clk_div #(.DIV(DIV)) clk_div_i (
    .clk     (SYS_CLK),
    .rst     (RESET),
    .clk_out (SDRAM_CLK_OUT),
    .rise_en (rise_en),
    .fall_en (fall_en)
  );

  sdram_sync2 #(.W(2)) mode_sync_i (
    .clk (SYS_CLK),
    .d   ({LANE_SELECT_PIN, ENDIAN_MODE_PIN}),
    .q   (mode_sync)
  );

  // Read data arrives on the SDRAM clock, so it is resynchronised here
  sdram_sync2 #(.W(64)) dq_sync_i (
    .clk (SYS_CLK),
    .d   (SDRAM_DATA_IO_IN),
    .q   (dq_sync)
  );

  assign in_a2 = (REQ.addr >= `AREA2_BASE) && (REQ.addr <= `AREA2_LAST);
  assign in_a3 = (REQ.addr >= `AREA3_BASE) && (REQ.addr <= `AREA3_LAST);
  assign take  = REQ_VALID && REQ_READY;
  assign lanes = lanes_of(width_reg);
  assign word  = cur_reg.addr >> ((width_reg == W64) ? 3 : (width_reg == W32) ? 2 : 1);

  always_comb begin
    issue_act = fall_en && (state_reg == ST_IDLE) && busy_reg && cke_reg;
    issue_col = fall_en && (state_reg == ST_RCD) && (cnt_reg == 4'h0);
    capture   = fall_en && (state_reg == ST_CAS) && (cnt_reg == 4'h0);
  end

  // Mode pins are followed while reset is held and frozen on release
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      little_reg <= mode_sync[0];
      lane_reg   <= mode_sync[1];
      UPPER_LANES_SDRAM <= ~mode_sync[1];
    end
  end

  assign LITTLE_ENDIAN     = little_reg;

  // Request acceptance and area decode
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      REQ_READY      <= 1'b0;
      REQ_IGNORED    <= 1'b0;
      busy_reg       <= 1'b0;
      area3_reg      <= 1'b0;
      width_reg      <= W16;
      cur_reg        <= '0;
      WIDTH_CONFLICT <= 1'b0;
    end else begin
      REQ_IGNORED <= 1'b0;
      if (take && (in_a2 || in_a3)) begin
        REQ_READY      <= 1'b0;
        busy_reg       <= 1'b1;
        cur_reg        <= REQ;
        area3_reg      <= in_a3;
        width_reg      <= in_a3 ? BUS_WIDTH_FIELD_B : BUS_WIDTH_FIELD_A;
        WIDTH_CONFLICT <= ((in_a3 ? BUS_WIDTH_FIELD_B : BUS_WIDTH_FIELD_A) == W64)
                          && lane_reg;
      end else if (take) begin
        REQ_IGNORED <= 1'b1;
      end else if (state_reg == ST_DONE) begin
        busy_reg  <= 1'b0;
        REQ_READY <= 1'b1;
      end else if (!busy_reg) begin
        REQ_READY <= 1'b1;
      end
    end
  end

  // Access sequence, advanced on SDRAM clock falls; DONE returns to idle on the next system clock
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      state_reg <= ST_IDLE;
      cnt_reg   <= 4'h0;
    end else begin
      unique case (state_reg)
        ST_IDLE: if (issue_act) begin
          state_reg <= ST_RCD;
          cnt_reg   <= 4'(TRCD - 1);
        end
        ST_RCD: if (issue_col) begin
          state_reg <= cur_reg.write ? ST_WREL : ST_CAS;
          cnt_reg   <= 4'(CAS_LAT);
        end else if (fall_en) begin
          cnt_reg <= cnt_reg - 4'h1;
        end
        ST_CAS: if (capture) begin
          state_reg <= ST_DONE;
        end else if (fall_en) begin
          cnt_reg <= cnt_reg - 4'h1;
        end
        ST_WREL: if (fall_en) begin
          state_reg <= ST_DONE;
        end
        ST_DONE: state_reg <= ST_IDLE;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Command pins change one system clock after the SDRAM clock falls, before the rise that samples them
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      cmd_reg        <= '{cs2_n: 1'b1, cs3_n: 1'b1, rcw: `CMD_NOP};
      SDRAM_ADDR_OUT <= '0;
      BYTE_MASK      <= 8'hFF;
    end else if (fall_en) begin
      cmd_reg   <= '{cs2_n: 1'b1, cs3_n: 1'b1, rcw: `CMD_NOP};
      BYTE_MASK <= 8'hFF;
      if (issue_act) begin
        cmd_reg        <= '{cs2_n: area3_reg, cs3_n: ~area3_reg, rcw: `CMD_ACT};
        SDRAM_ADDR_OUT <= `SDRAM_ADDR_W'(word[COL_BITS +: ROW_BITS]);
      end else if (issue_col) begin
        cmd_reg <= '{cs2_n: area3_reg, cs3_n: ~area3_reg,
                     rcw: cur_reg.write ? `CMD_WRITE : `CMD_READ};
        // Auto-precharge keeps one bank row open per access only
        SDRAM_ADDR_OUT <= `SDRAM_ADDR_W'(word[COL_BITS-1:0])
                          | (`SDRAM_ADDR_W'(1) << `AUTO_PRE_BIT);
        BYTE_MASK <= cur_reg.write
                     ? ~(order_bits(cur_reg.be, width_reg, ~little_reg) & lanes)
                     : ~lanes;
      end
    end
  end

  assign AREA2_SELECT_N   = cmd_reg.cs2_n;
  assign AREA3_SELECT_N   = cmd_reg.cs3_n;
  assign ROW_STROBE_N     = cmd_reg.rcw[2];
  assign COL_STROBE_N     = cmd_reg.rcw[1];
  assign SDRAM_WRITE_EN_N = cmd_reg.rcw[0];

  // Data bus drive and read capture
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      SDRAM_DATA_IO_OE  <= 1'b0;
      SDRAM_DATA_IO_OUT <= '0;
      RD_VALID          <= 1'b0;
      RD_DATA           <= '0;
      WR_DONE           <= 1'b0;
    end else begin
      RD_VALID <= capture;
      WR_DONE  <= fall_en && (state_reg == ST_WREL);
      if (issue_col && cur_reg.write) begin
        SDRAM_DATA_IO_OE  <= 1'b1;
        SDRAM_DATA_IO_OUT <= order_bytes(cur_reg.wdata, width_reg, ~little_reg);
      end else if (fall_en) begin
        SDRAM_DATA_IO_OE <= 1'b0;
      end
      if (capture) begin
        RD_DATA <= order_bytes(dq_sync & {{8{lanes[7]}}, {8{lanes[6]}}, {8{lanes[5]}},
                   {8{lanes[4]}}, {8{lanes[3]}}, {8{lanes[2]}}, {8{lanes[1]}},
                   {8{lanes[0]}}}, width_reg, ~little_reg);
      end
    end
  end

  // Power-down only from idle, so no command meets a low clock enable
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      cke_reg <= 1'b1;
    end else if (fall_en) begin
      cke_reg <= ~(LOW_POWER && (state_reg == ST_IDLE) && !busy_reg);
    end
  end

  assign SDRAM_CLK_EN = cke_reg;

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);

  area_two_sel_a: assert property (!AREA2_SELECT_N |->
    (cur_reg.addr >= `AREA2_BASE) && (cur_reg.addr <= `AREA2_LAST))
    else $error("area two select outside its range");
  area_three_sel_a: assert property (!AREA3_SELECT_N |->
    (cur_reg.addr >= `AREA3_BASE) && (cur_reg.addr <= `AREA3_LAST))
    else $error("area three select outside its range");
  other_area_quiet_a: assert property (REQ_VALID && REQ_READY && !in_a2 && !in_a3
    |=> REQ_IGNORED && !busy_reg)
    else $error("foreign area request was taken");
  unused_lanes_a: assert property ((~BYTE_MASK & ~lanes) == 8'h00)
    else $error("unused lane unmasked");
  lane_conflict_a: assert property ($fell(COL_STROBE_N) && width_reg == W64
    |-> WIDTH_CONFLICT == lane_reg)
    else $error("lane conflict flag wrong");
  endian_hold_a: assert property ($past(!RESET) |-> $stable(LITTLE_ENDIAN))
    else $error("endian changed after reset");
  write_line_a: assert property (!COL_STROBE_N |->
    (SDRAM_WRITE_EN_N != SDRAM_DATA_IO_OE))
    else $error("write line disagrees with data drive");
  row_col_order_a: assert property ($fell(ROW_STROBE_N) |-> ##[1:64] $fell(COL_STROBE_N))
    else $error("column command missing after activate");
  cke_idle_a: assert property (!SDRAM_CLK_EN |-> ROW_STROBE_N && COL_STROBE_N)
    else $error("command while clock enable low");
  clk_runs_a: assert property ($rose(SDRAM_CLK_OUT) |-> ##[1:16] $fell(SDRAM_CLK_OUT))
    else $error("sdram clock stalled");
  drive_write_a: assert property (SDRAM_DATA_IO_OE |->
    !COL_STROBE_N && !SDRAM_WRITE_EN_N)
    else $error("data driven outside write phase");
  cmd_legal_a: assert property ((!ROW_STROBE_N || !COL_STROBE_N) |->
    (AREA2_SELECT_N != AREA3_SELECT_N) && (ROW_STROBE_N != COL_STROBE_N))
    else $error("illegal command encoding");

  read_done_c: cover property (RD_VALID);
  write_done_c: cover property (WR_DONE);
  ignored_c: cover property (REQ_IGNORED);
  power_down_c: cover property (!SDRAM_CLK_EN ##1 SDRAM_CLK_EN);
endmodule : sdram_area_port

// File: sdram_defines.svh
// Constants for the SDRAM area port
`ifndef SDRAM_AREA_PORT_DEFINES_SVH
`define SDRAM_AREA_PORT_DEFINES_SVH

`define ADDR_W        29
`define AREA2_BASE    29'h0800_0000
`define AREA2_LAST    29'h0BFF_FFFF
`define AREA3_BASE    29'h0C00_0000
`define AREA3_LAST    29'h0FFF_FFFF
`define AREA7_BASE    29'h1C00_0000
`define AREA7_LAST    29'h1FFF_FFFF

`define WIDTH_CODE16  2'h0
`define WIDTH_CODE32  2'h1
`define WIDTH_CODE64  2'h2
`define WIDTH_CODERSV 2'h3

`define CMD_NOP       3'h7
`define CMD_ACT       3'h3
`define CMD_READ      3'h5
`define CMD_WRITE     3'h4

`define CLK_DIV       4
`define TRCD_CK       1
`define CAS_LAT       2
`define COL_BITS      9
`define ROW_BITS      13
`define AUTO_PRE_BIT  10
`define SDRAM_ADDR_W  16
`define LANES_16      8'h03
`define LANES_32      8'h0F
`define LANES_64      8'hFF

`endif

// File: sdram_pkg.sv
// Types shared by the SDRAM area port
package sdram_pkg;
  `include "sdram_defines.svh"

  typedef enum logic [1:0] {
    W16 = `WIDTH_CODE16,
    W32 = `WIDTH_CODE32,
    W64 = `WIDTH_CODE64,
    WRS = `WIDTH_CODERSV
  } width_e;

  typedef struct packed {
    logic [`ADDR_W-1:0] addr;
    logic               write;
    logic [63:0]        wdata;
    logic [7:0]         be;
  } req_s;

  typedef struct packed {
    logic       cs2_n;
    logic       cs3_n;
    logic [2:0] rcw;
  } cmd_s;
endpackage : sdram_pkg

// File: sdram_sync2.sv
// Two-flop synchroniser for inputs from outside the clock domain
`timescale 1ns/1ps
module sdram_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_reg;

  // No reset: mode capture reads this path while reset is held
  always_ff @(posedge clk) begin
    meta_reg <= d;
    q        <= meta_reg;
  end
endmodule : sdram_sync2

// File: sdram_clk_div.sv
// Divider making the SDRAM clock and its edge enables
`timescale 1ns/1ps
module sdram_clk_div #(
  parameter int DIV = 4
) (
  input  wire logic clk,
  input  wire logic rst,
  output logic      clk_out,
  output logic      rise_en,
  output logic      fall_en
);
  localparam int HALF = DIV / 2;
  logic [7:0] cnt_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_reg <= 8'h00;
      clk_out <= 1'b0;
      rise_en <= 1'b0;
      fall_en <= 1'b0;
    end else begin
      rise_en <= 1'b0;
      fall_en <= 1'b0;
      if (cnt_reg == 8'(DIV - 1)) begin
        cnt_reg <= 8'h00;
        clk_out <= 1'b1;
        rise_en <= 1'b1;
      end else begin
        cnt_reg <= cnt_reg + 8'h01;
        if (cnt_reg == 8'(HALF - 1)) begin
          clk_out <= 1'b0;
          fall_en <= 1'b1;
        end
      end
    end
  end
endmodule : sdram_clk_div

// File: sdram_model.sv
// Behavioural SDRAM answering on the area port's pins
`timescale 1ns/1ps
module sdram_model #(
  parameter int CL = 2
) (
  input  wire logic        clk_sd,
  input  wire logic        cke,
  input  wire logic        cs2_n,
  input  wire logic        cs3_n,
  input  wire logic        ras_n,
  input  wire logic        cas_n,
  input  wire logic        we_n,
  input  wire logic [7:0]  mask,
  input  wire logic [15:0] addr,
  input  wire logic [63:0] wdata,
  output logic      [63:0] dq
);
  logic [63:0] mem [logic [22:0]];
  logic [12:0] row [2] = '{13'h0000, 13'h0000};
  logic [22:0] key;
  logic [63:0] val;
  logic [63:0] rdv;

  initial dq = 64'h0;

  // Commands sampled on the SDRAM clock rise, only while enabled
  always @(posedge clk_sd) begin
    if (cke && !(cs2_n && cs3_n)) begin
      key = {!cs3_n, row[!cs3_n], addr[8:0]};
      val = mem.exists(key) ? mem[key] : 64'h0;
      case ({ras_n, cas_n, we_n})
        3'b011: row[!cs3_n] = addr[12:0];
        3'b100: begin
          for (int k = 0; k < 8; k++)
            if (!mask[k]) val[8*k +: 8] = wdata[8*k +: 8];
          mem[key] = val;
        end
        3'b101: begin
          rdv = val;
          fork
            begin
              repeat (CL - 1) @(posedge clk_sd);
              #1 dq = rdv;
              @(posedge clk_sd);
              @(negedge clk_sd);
              // Released bus must not look like valid data
              dq = ~rdv;
            end
          join_none
        end
        default: ;
      endcase
    end
  end
endmodule : sdram_model

// File: sdram_area_port_tb.sv
// Self-checking bench for the SDRAM area port
`timescale 1ns/1ps
module sdram_area_port_tb
  import sdram_pkg::*;
;
  localparam int DIV = 4;
  logic   SYS_CLK = 0, RESET = 1, REQ_VALID = 0, LOW_POWER = 0;
  logic   ENDIAN_MODE_PIN = 1, LANE_SELECT_PIN = 0;
  req_s   REQ = '0;
  width_e BUS_WIDTH_FIELD_A = W64, BUS_WIDTH_FIELD_B = W64;
  logic   REQ_READY, REQ_IGNORED, RD_VALID, WR_DONE, LITTLE_ENDIAN, UPPER_LANES_SDRAM;
  logic   WIDTH_CONFLICT, SDRAM_DATA_IO_OE, AREA2_SELECT_N, AREA3_SELECT_N, ROW_STROBE_N;
  logic   COL_STROBE_N, SDRAM_WRITE_EN_N, SDRAM_CLK_EN, SDRAM_CLK_OUT, cmd_we;
  logic   [63:0] RD_DATA, SDRAM_DATA_IO_OUT, model_dq, pad, cmd_data;
  logic   [15:0] SDRAM_ADDR_OUT, act_addr, cmd_addr;
  logic   [7:0]  BYTE_MASK, cmd_mask;
  int     n_s2, n_s3, n_act, n_oe, miscompares, n_checks, cycles;

  assign pad = SDRAM_DATA_IO_OE ? SDRAM_DATA_IO_OUT : model_dq;

  sdram_area_port uut (.SYS_CLK, .RESET, .REQ_VALID, .REQ, .REQ_READY, .REQ_IGNORED,
    .RD_VALID, .RD_DATA, .WR_DONE, .BUS_WIDTH_FIELD_A, .BUS_WIDTH_FIELD_B, .LOW_POWER,
    .ENDIAN_MODE_PIN, .LANE_SELECT_PIN, .LITTLE_ENDIAN, .UPPER_LANES_SDRAM, .WIDTH_CONFLICT,
    .SDRAM_ADDR_OUT, .SDRAM_DATA_IO_OUT, .SDRAM_DATA_IO_OE, .SDRAM_DATA_IO_IN(pad),
    .AREA2_SELECT_N, .AREA3_SELECT_N, .ROW_STROBE_N, .COL_STROBE_N, .SDRAM_WRITE_EN_N,
    .BYTE_MASK, .SDRAM_CLK_EN, .SDRAM_CLK_OUT);

  sdram_model #(.CL(2)) mdl (.clk_sd(SDRAM_CLK_OUT), .cke(SDRAM_CLK_EN),
    .cs2_n(AREA2_SELECT_N), .cs3_n(AREA3_SELECT_N), .ras_n(ROW_STROBE_N),
    .cas_n(COL_STROBE_N), .we_n(SDRAM_WRITE_EN_N), .mask(BYTE_MASK),
    .addr(SDRAM_ADDR_OUT), .wdata(pad), .dq(model_dq));

  initial forever #2.5 SYS_CLK = ~SYS_CLK;

  // Pin activity counters; run is about 1000 cycles, so the ceiling is generous
  always @(posedge SYS_CLK) begin
    cycles++;
    if (!AREA2_SELECT_N) n_s2++;
    if (!AREA3_SELECT_N) n_s3++;
    if (!ROW_STROBE_N && COL_STROBE_N) begin
      n_act++;
      act_addr = SDRAM_ADDR_OUT;
    end
    if (SDRAM_DATA_IO_OE) n_oe++;
    if (ROW_STROBE_N && !COL_STROBE_N && !(AREA2_SELECT_N && AREA3_SELECT_N)) begin
      cmd_we = SDRAM_WRITE_EN_N;
      cmd_mask = BYTE_MASK;
      cmd_data = SDRAM_DATA_IO_OUT;
      cmd_addr = SDRAM_ADDR_OUT;
    end
    if (cycles == 30000) begin
      miscompares++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : complete_run

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic do_reset(input logic endian, input logic lane);
    @(posedge SYS_CLK);
    RESET <= 1'b1;
    ENDIAN_MODE_PIN <= endian;
    LANE_SELECT_PIN <= lane;
    repeat (6) @(posedge SYS_CLK);
    RESET <= 1'b0;
    repeat (2) @(posedge SYS_CLK);
  endtask : do_reset

  // One access, held until taken, then bounded wait for its answer
  task automatic do_req(input logic [28:0] a, input logic wr, input logic [63:0] d,
                        input logic [7:0] be, output logic ign, output logic [63:0] rd);
    int t;
    @(posedge SYS_CLK);
    REQ_VALID <= 1'b1;
    REQ <= '{addr: a, write: wr, wdata: d, be: be};
    @(negedge SYS_CLK);
    for (t = 0; t < 80 && REQ_READY !== 1'b1; t++) @(negedge SYS_CLK);
    @(posedge SYS_CLK);
    REQ_VALID <= 1'b0;
    for (t = 0; t < 80; t++) begin
      @(negedge SYS_CLK);
      if (WR_DONE === 1'b1 || RD_VALID === 1'b1 || REQ_IGNORED === 1'b1) break;
    end
    check(t < 80, 1'b1);
    ign = REQ_IGNORED;
    rd = RD_DATA;
  endtask : do_req

  // Expected lanes and masks: mirrored within the width for big endian
  function automatic logic [71:0] image(input logic [63:0] d, input logic [7:0] be,
                                        input int n, input logic big);
    logic [63:0] o;
    logic [7:0]  m;
    int j;
    o = 64'h0;
    m = 8'hFF;
    for (int k = 0; k < n; k++) begin
      j = big ? n - 1 - k : k;
      o[8*j +: 8] = d[8*k +: 8];
      m[j] = ~be[k];
    end
    return {m, o};
  endfunction : image

  task automatic run_widths(input logic big);
    logic [71:0] im;
    logic [63:0] rd, ex, keep, d1, d2;
    logic [28:0] ad, wd;
    logic ign;
    int n, a2, a3, oe0, act0;
    for (int c = 0; c < 4; c++) begin
      n = (c == 1) ? 4 : (c == 2) ? 8 : 2;
      d1 = 64'h0123_4567_89AB_CDEF + 64'(c);
      d2 = 64'hFEDC_BA98_7654_3210 - 64'(c);
      for (int a = 0; a < 2; a++) begin
        ad = a ? 29'h0C00_4560 : 29'h0800_1230;
        // Idle area gets another width, so a swapped field shows up
        @(posedge SYS_CLK);
        BUS_WIDTH_FIELD_A <= a ? width_e'(c ^ 1) : width_e'(c);
        BUS_WIDTH_FIELD_B <= a ? width_e'(c) : width_e'(c ^ 1);
        do_req(ad, 1'b1, d1, 8'hFF, ign, rd);
        a2 = n_s2;
        a3 = n_s3;
        oe0 = n_oe;
        do_req(ad, 1'b1, d2, 8'h5A, ign, rd);
        im = image(d2, 8'h5A, n, big);
        keep = 64'h0;
        for (int k = 0; k < 8; k++) if (!im[64+k]) keep[8*k +: 8] = 8'hFF;
        check(cmd_mask, im[71:64]);
        check(cmd_data & keep, im[63:0] & keep);
        check(cmd_we, 1'b0);
        check((a ? n_s3 - a3 : n_s2 - a2) > 0, 1'b1);
        check((n_oe - oe0) > 0, 1'b1);
        wd = ad >> ((n == 8) ? 3 : (n == 4) ? 2 : 1);
        check(act_addr, 16'(wd[21:9]));
        check(cmd_addr, 16'(wd[8:0]) | 16'h0400);
        oe0 = n_oe;
        act0 = n_act;
        do_req(ad, 1'b0, 64'h0, 8'hFF, ign, rd);
        ex = 64'h0;
        for (int k = 0; k < n; k++) ex[8*k +: 8] = k[0] ^ k[1] ^ k[2] ^ (k < 4) ?
          ((8'h5A >> k) & 8'h01 ? d2[8*k +: 8] : d1[8*k +: 8]) :
          ((8'h5A >> k) & 8'h01 ? d2[8*k +: 8] : d1[8*k +: 8]);
        check(rd, ex);
        check(cmd_we, 1'b1);
        check(cmd_mask, 8'(8'hFF << n));
        check(n_oe - oe0, 0);
        check(n_act - act0, DIV);
      end
    end
  endtask : run_widths

  // Reserved area never addressed
  logic [28:0] dec_a [8] = '{29'h0000_0000, 29'h07FF_FFFF, 29'h0800_0000, 29'h0BFF_FFFF,
                             29'h0C00_0000, 29'h0FFF_FFFF, 29'h1000_0000, 29'h1BFF_FFFF};
  int dec_k [8] = '{0, 0, 2, 2, 3, 3, 0, 0};

  initial begin
    logic ign, prev;
    logic [63:0] rd;
    int a2, a3, act0, r;
    do_reset(1'b1, 1'b0);
    check(LITTLE_ENDIAN, 1'b1);
    check(UPPER_LANES_SDRAM, 1'b1);
    check(SDRAM_CLK_EN, 1'b1);
    check(WIDTH_CONFLICT, 1'b0);
    $display("test mode pins done");
    prev = SDRAM_CLK_OUT;
    r = 0;
    for (int i = 0; i < 40; i++) begin
      @(negedge SYS_CLK);
      if (!prev && SDRAM_CLK_OUT) r++;
      prev = SDRAM_CLK_OUT;
    end
    check(r, 40 / DIV);
    $display("test sdram clock done");
    for (int i = 0; i < 8; i++) begin
      a2 = n_s2;
      a3 = n_s3;
      act0 = n_act;
      do_req(dec_a[i], 1'b1, 64'h5555_AAAA_0F0F_F0F0, 8'hFF, ign, rd);
      check(ign, dec_k[i] == 0);
      check((n_s2 - a2) > 0, dec_k[i] == 2);
      check((n_s3 - a3) > 0, dec_k[i] == 3);
      check((n_act - act0) > 0, dec_k[i] != 0);
    end
    $display("test area decode done");
    run_widths(1'b0);
    $display("test little endian widths done");
    @(posedge SYS_CLK);
    LOW_POWER <= 1'b1;
    repeat (20) @(negedge SYS_CLK);
    check(SDRAM_CLK_EN, 1'b0);
    @(posedge SYS_CLK);
    LOW_POWER <= 1'b0;
    repeat (20) @(negedge SYS_CLK);
    check(SDRAM_CLK_EN, 1'b1);
    $display("test low power done");
    do_reset(1'b0, 1'b0);
    check(LITTLE_ENDIAN, 1'b0);
    run_widths(1'b1);
    $display("test big endian widths done");
    do_reset(1'b1, 1'b1);
    check(UPPER_LANES_SDRAM, 1'b0);
    BUS_WIDTH_FIELD_A <= W32;
    do_req(29'h0800_0040, 1'b1, 64'h1, 8'h0F, ign, rd);
    check(WIDTH_CONFLICT, 1'b0);
    @(posedge SYS_CLK);
    BUS_WIDTH_FIELD_A <= W64;
    do_req(29'h0800_0080, 1'b1, 64'h2, 8'hFF, ign, rd);
    check(WIDTH_CONFLICT, 1'b1);
    $display("test lane select done");
    complete_run();
  end
endmodule : sdram_area_port_tb
